//--- sim/cfic_rf_model.sv
// register file stand-in that answers the indirect access port
`timescale 1ns/1ps
module cfic_rf_model (
  input  wire logic       aclk,
  input  wire logic [7:0] rf_addr,
  input  wire logic       rf_rd,
  input  wire logic       rf_wr,
  input  wire logic [7:0] rf_wdata,
  output logic      [7:0] rf_rdata
);
  // ****************************************
  // storage and read port
  // ****************************************
  logic [7:0] mem [256];
  logic [7:0] hold_q   = 8'h00;
  logic       hold_v_q = 1'h0;
  int         wr_count = 0;

  // writes land at the strobe; read data held one cycle, then scrambled
  always @(posedge aclk) begin
    if (rf_wr) begin
      mem[rf_addr] <= rf_wdata;
      wr_count     <= wr_count + 1;
    end
    hold_v_q <= rf_rd;
    hold_q   <= rf_rd ? mem[rf_addr] : ~hold_q;
  end

  // valid in the strobe cycle and the next; after that the output alternates and equals the stale data every other cycle
  assign rf_rdata = rf_rd ? mem[rf_addr] : (hold_v_q ? hold_q : ~hold_q);
endmodule : cfic_rf_model

//--- sim/tb.sv
// self-checking bench for the program-flow and interrupt control block
`timescale 1ns/1ps
`include "cfic_map.svh"
module tb;
  import cfic_pkg::*;
  // ****************************************
  // stimulus signals and design
  // ****************************************
  logic        aclk = 1'h0, aresetn = 1'h0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0, rdata_q, rd;
  logic [3:0]  wstrb = 4'hF, change_watch_pins = 4'h0;
  logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q, irq_request_q;
  logic        rf_rd_q, rf_wr_q;
  logic [1:0]  bresp_q, rresp_q, resp;
  cfic_op_t    seq_op = CFIC_OP_NONE;
  logic [10:0] seq_target = 11'h000;
  logic [12:0] program_counter_q;
  logic        timer_overflow = 1'h0, ext_pin_event = 1'h0, eeprom_done_flag = 1'h0;
  logic [7:0]  rf_addr_q, rf_wdata_q, rf_rdata;
  int          checks = 0, miscompares = 0;

  cfic_top i_cfic_top (
    .aclk, .aresetn, .awaddr, .awvalid, .awready_q, .wdata, .wstrb, .wvalid, .wready_q,
    .bresp_q, .bvalid_q, .bready, .araddr, .arvalid, .arready_q, .rdata_q, .rresp_q,
    .rvalid_q, .rready, .seq_op, .seq_target, .program_counter_q, .irq_request_q,
    .timer_overflow, .ext_pin_event, .change_watch_pins, .eeprom_done_flag,
    .rf_addr_q, .rf_rd_q, .rf_wr_q, .rf_wdata_q, .rf_rdata
  );
  cfic_rf_model i_cfic_rf_model (.aclk, .rf_addr(rf_addr_q), .rf_rd(rf_rd_q),
    .rf_wr(rf_wr_q), .rf_wdata(rf_wdata_q), .rf_rdata);

  // 50 MHz clock
  initial begin
    forever #10 aclk = ~aclk;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic finish_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  // a wait that ran out of its bound ends the run
  task automatic tmo(input int n);
    if (n >= 50) begin
      miscompares++;
      $display("MISMATCH bus_wait exp answer got none");
      finish_test;
    end
  endtask : tmo

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  // both channels offered together, each released when taken
  task automatic axi_wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] st = 4'hF);
    int n = 0;
    @(posedge aclk);
    awaddr  <= {2'h0, idx, 2'h0};
    wdata   <= {24'h0, d};
    wstrb   <= st;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready_q) awvalid <= 1'h0;
      if (wvalid && wready_q) wvalid <= 1'h0;
    end while (!bvalid_q && n < 50);
    bready <= 1'h0;
    resp = bresp_q;
    tmo(n);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] idx);
    int n = 0;
    @(posedge aclk);
    araddr  <= {2'h0, idx, 2'h0};
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready_q) arvalid <= 1'h0;
    end while (!rvalid_q && n < 50);
    rready <= 1'h0;
    rd = rdata_q;
    resp = rresp_q;
    tmo(n);
  endtask : axi_rd

  // one sequencer command, counter settled on return
  task automatic seq(input cfic_op_t op, input logic [10:0] t);
    @(posedge aclk);
    seq_op     <= op;
    seq_target <= t;
    @(posedge aclk);
    seq_op <= CFIC_OP_NONE;
    #1;
  endtask : seq

  // source 0 eeprom level, 1 timer, 2 pin, 3 watched pins
  task automatic fire(input int s, input logic v);
    case (s)
      0: eeprom_done_flag <= v;
      1: timer_overflow <= v;
      2: ext_pin_event <= v;
      default: if (v) change_watch_pins <= ~change_watch_pins;
    endcase
  endtask : fire

  // ****************************************
  // scenarios
  // ****************************************
  task automatic test_reset;
    axi_rd(`CFIC_IDX_INTERRUPT_CONTROL);
    chk("interrupt_control_rst", rd & 32'hFE, 32'h0);
    axi_rd(`CFIC_IDX_PCH);
    chk("hold_rst", rd, 32'h0);
    chk("pc_rst", program_counter_q, 32'h0);
  endtask : test_reset

  // flag, own enable and global enable all needed
  task automatic test_irq;
    logic [7:0] en, fl;
    for (int s = 0; s < 4; s++) begin
      en = 8'h40 >> s;
      fl = (s == 0) ? 8'h00 : (8'h08 >> s);
      axi_wr(`CFIC_IDX_INTERRUPT_CONTROL, 8'h00);
      @(posedge aclk);
      fire(s, 1'h1);
      @(posedge aclk);
      if (s != 0) fire(s, 1'h0);
      cyc(3);
      axi_rd(`CFIC_IDX_INTERRUPT_CONTROL);
      chk("flag_set", rd, {24'h0, fl});
      axi_wr(`CFIC_IDX_INTERRUPT_CONTROL, en | fl);
      cyc(2);
      chk("irq_no_global", irq_request_q, 32'h0);
      axi_wr(`CFIC_IDX_INTERRUPT_CONTROL, 8'h80 | fl);
      cyc(2);
      chk("irq_no_enable", irq_request_q, 32'h0);
      axi_wr(`CFIC_IDX_INTERRUPT_CONTROL, 8'h80 | en | fl);
      cyc(2);
      chk("irq_all_set", irq_request_q, 32'h1);
      cyc(5);
      axi_rd(`CFIC_IDX_INTERRUPT_CONTROL);
      chk("flag_sticky", rd, {24'h0, 8'h80 | en | fl});
      fire(s, 1'h0);
      axi_wr(`CFIC_IDX_INTERRUPT_CONTROL, 8'h80 | en);
      cyc(2);
      chk("irq_cleared", irq_request_q, 32'h0);
      axi_rd(`CFIC_IDX_INTERRUPT_CONTROL);
      chk("flag_clear", rd, {24'h0, 8'h80 | en});
    end
  endtask : test_irq

  // nine pushes wrap, nine pops return to the first pop
  task automatic test_flow;
    logic [12:0] cur;
    logic [12:0] pushed [9];
    cfic_op_t    rets [3];
    rets = '{CFIC_OP_RET, CFIC_OP_RET_LIT, CFIC_OP_RET_HANDLER};
    axi_wr(`CFIC_IDX_PCH, 8'h05);
    axi_wr(`CFIC_IDX_PCL, 8'h45);
    cyc(2);
    chk("pc_low_write", program_counter_q, 32'h0545);
    axi_rd(`CFIC_IDX_PCL);
    chk("pc_low_read", rd, 32'h45);
    seq(CFIC_OP_STEP, 11'h000);
    chk("pc_step", program_counter_q, 32'h0546);
    axi_wr(`CFIC_IDX_PCH, 8'h1F);
    seq(CFIC_OP_JUMP, 11'h456);
    chk("pc_jump", program_counter_q, 32'h0456);
    cur = 13'h0456;
    for (int i = 0; i < 9; i++) begin
      pushed[i] = cur;
      cur = (i == 4) ? 13'h0004 : {2'h0, 11'h7F0 + 11'(i)};
      seq((i == 4) ? CFIC_OP_IRQ_ACK : CFIC_OP_CALL, 11'h7F0 + 11'(i));
      chk("pc_call", program_counter_q, {19'h0, cur});
    end
    axi_rd(`CFIC_IDX_PCH);
    chk("hold_after_push", rd, 32'h1F);
    for (int j = 0; j < 9; j++) begin
      seq(rets[j % 3], 11'h000);
      chk("pc_pop", program_counter_q, {19'h0, pushed[(j == 8) ? 8 : 8 - j]});
    end
    axi_rd(`CFIC_IDX_PCH);
    chk("hold_after_pop", rd, 32'h1F);
    // call and return on back-to-back edges
    @(posedge aclk);
    seq_op     <= CFIC_OP_CALL;
    seq_target <= 11'h123;
    @(posedge aclk);
    seq_op <= CFIC_OP_RET;
    @(posedge aclk);
    seq_op <= CFIC_OP_NONE;
    #1;
    chk("pc_call_ret", program_counter_q, {19'h0, pushed[8]});
  endtask : test_flow

  // window follows the pointer; pointer zero is inert
  task automatic test_indirect;
    int n0;
    for (int k = 0; k < 2; k++) begin
      axi_wr(`CFIC_IDX_PTR, 8'h20 + 8'(k));
      axi_wr(`CFIC_IDX_WINDOW, k ? 8'hA5 : 8'h5A);
    end
    for (int k = 0; k < 2; k++) begin
      axi_wr(`CFIC_IDX_PTR, 8'h20 + 8'(k));
      axi_rd(`CFIC_IDX_WINDOW);
      chk("window_read", rd, k ? 32'hA5 : 32'h5A);
      chk("rf_stored", i_cfic_rf_model.mem[8'h20 + 8'(k)], k ? 32'hA5 : 32'h5A);
    end
    axi_wr(`CFIC_IDX_PTR, `CFIC_IDX_PCH);
    axi_wr(`CFIC_IDX_WINDOW, 8'h03);
    axi_rd(`CFIC_IDX_PCH);
    chk("window_own_reg", rd, 32'h03);
    axi_wr(`CFIC_IDX_PTR, 8'h00);
    n0 = i_cfic_rf_model.wr_count;
    axi_wr(`CFIC_IDX_WINDOW, 8'h77);
    cyc(2);
    chk("window_self_wr", i_cfic_rf_model.wr_count, n0);
    axi_rd(`CFIC_IDX_WINDOW);
    chk("window_self_rd", rd, 32'h0);
  endtask : test_indirect

  // unmapped place and a write with its byte lane off
  task automatic test_bus;
    axi_wr(8'h3F, 8'h11);
    chk("unmapped_bresp", resp, `CFIC_RESP_SLVERR);
    axi_rd(8'h3F);
    chk("unmapped_rresp", resp, `CFIC_RESP_SLVERR);
    chk("unmapped_rdata", rd, 32'h0);
    axi_wr(`CFIC_IDX_PTR, 8'h99, 4'h0);
    chk("nostrb_bresp", resp, `CFIC_RESP_OKAY);
    axi_rd(`CFIC_IDX_PTR);
    chk("nostrb_data", rd, 32'h0);
  endtask : test_bus

  // reset for six cycles, then the scenarios in turn
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    cyc(3);
    test_reset;
    test_irq;
    test_flow;
    test_indirect;
    test_bus;
    finish_test;
  end
endmodule : tb

//--- verilog/cfic_map.svh
// register indices, field positions, reset values and fixed constants of the flow block
`ifndef CFIC_MAP_SVH
`define CFIC_MAP_SVH

// register indices; byte address on the bus is four times the index
`define CFIC_IDX_WINDOW   8'h00
`define CFIC_IDX_PCL      8'h02
`define CFIC_IDX_PTR      8'h04
`define CFIC_IDX_PCH      8'h0A
`define CFIC_IDX_INTERRUPT_CONTROL   8'h0B

// interrupt_control field positions
`define CFIC_B_GIE        7
`define CFIC_B_EN_HI      6
`define CFIC_B_EN_LO      3
`define CFIC_B_TMR_FLAG   2
`define CFIC_B_EXT_FLAG   1
`define CFIC_B_CHG_FLAG   0

// widths and sizes
`define CFIC_ADDR_W       12
`define CFIC_PC_W         13
`define CFIC_TGT_W        11
`define CFIC_PCH_W        5
`define CFIC_STK_DEPTH    8
`define CFIC_STK_PTR_W    3

// fixed values
`define CFIC_PAGE_ZERO    2'h0
`define CFIC_IRQ_VECTOR   13'h0004
`define CFIC_PC_RESET     13'h0000
`define CFIC_PC_ONE       13'h0001
`define CFIC_BYTE_ZERO    8'h00
`define CFIC_EN_RESET     4'h0
`define CFIC_PCH_RESET    5'h00
`define CFIC_PAD_ZERO     3'h0
`define CFIC_RDATA_PAD    24'h000000
`define CFIC_HI_ZERO      2'h0
`define CFIC_PTR_ONE      3'h1
`define CFIC_PTR_TWO      3'h2
`define CFIC_RESP_OKAY    2'h0
`define CFIC_RESP_SLVERR  2'h2

`endif

//--- verilog/cfic_pkg.sv
// types shared by the program-flow and interrupt control block
package cfic_pkg;
  // sequencer commands
  typedef enum logic [2:0] {
    CFIC_OP_NONE        = 3'h0,
    CFIC_OP_STEP        = 3'h1,
    CFIC_OP_CALL        = 3'h2,
    CFIC_OP_JUMP        = 3'h3,
    CFIC_OP_RET         = 3'h4,
    CFIC_OP_RET_LIT     = 3'h5,
    CFIC_OP_RET_HANDLER = 3'h6,
    CFIC_OP_IRQ_ACK     = 3'h7
  } cfic_op_t;

  // bus read sequencing, one-hot
  typedef enum logic [2:0] {
    CFIC_RD_IDLE = 3'b001,
    CFIC_RD_EXT  = 3'b010,
    CFIC_RD_RESP = 3'b100
  } cfic_rd_state_t;
endpackage : cfic_pkg

//--- verilog/cfic_stack.sv
// circular eight-entry return stack with registered top-of-stack
`timescale 1ns/1ps
`include "cfic_map.svh"
module cfic_stack (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic                   push,
  input  wire logic                   pop,
  input  wire logic [`CFIC_PC_W-1:0]  push_data,
  output logic      [`CFIC_PC_W-1:0]  top_q
);
  import cfic_pkg::*;

  logic [`CFIC_PC_W-1:0]      mem [0:`CFIC_STK_DEPTH-1];
  logic [`CFIC_STK_PTR_W-1:0] ptr_q;

  // storage only, no reset: contents are undefined until pushed
  always_ff @(posedge aclk) begin
    if (push) begin
      mem[ptr_q] <= push_data;
    end
  end

  // circular pointer wrap
  // pointer wraps freely, so overflow and underflow go unnoticed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ptr_q <= '0;
      top_q <= `CFIC_PC_RESET;
    end else if (push) begin
      ptr_q <= ptr_q + `CFIC_PTR_ONE;
      top_q <= push_data;
    end else if (pop) begin
      ptr_q <= ptr_q - `CFIC_PTR_ONE;
      top_q <= mem[ptr_q - `CFIC_PTR_TWO];
    end
  end
endmodule : cfic_stack

//--- verilog/cfic_top.sv
// program counter, return stack, indirect access and interrupt control behind AXI4-Lite
// How it works
// - global enable passes unmasked interrupts when set, blocks all when clear
// - bits 6..3 enable eeprom, timer, external pin and port-change sources
// - timer flag bit 2 sets on overflow, only software clears it
// - external pin flag bit 1 sets on the external interrupt condition
// - port-change flag bit 0 sets on any watched pin change, software clears
// - flags set regardless of their own enable or the global enable
// - counter is 13 bits; only the low byte is visible as a register
// - only a low byte write takes upper bits from holding register
// - call and jump give an 11-bit target, page bits forced to page zero
// - page bits are ignored here since upper pages do not exist
// - eight by 13-bit return stack with a hidden pointer
// - push on call or interrupt acknowledge, pop on the three exits
// - push and pop leave the holding register alone
// - stack wraps: ninth push overwrites the first
// - nine pops in a row return the first pop's value again
// - no overflow or underflow status exists
// - window access reaches the location named by the pointer register
// - window read through pointer zero returns zero
// - window write through pointer zero changes nothing
// - bank-select bit above the pointer is unused, pointer alone addresses
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "cfic_map.svh"
module cfic_top (
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic [`CFIC_ADDR_W-1:0]  awaddr,
  input  wire logic                     awvalid,
  output logic                          awready_q,
  input  wire logic [31:0]              wdata,
  input  wire logic [3:0]               wstrb,
  input  wire logic                     wvalid,
  output logic                          wready_q,
  output logic [1:0]                    bresp_q,
  output logic                          bvalid_q,
  input  wire logic                     bready,
  input  wire logic [`CFIC_ADDR_W-1:0]  araddr,
  input  wire logic                     arvalid,
  output logic                          arready_q,
  output logic [31:0]                   rdata_q,
  output logic [1:0]                    rresp_q,
  output logic                          rvalid_q,
  input  wire logic                     rready,
  input  wire cfic_pkg::cfic_op_t       seq_op,
  input  wire logic [`CFIC_TGT_W-1:0]   seq_target,
  output logic [`CFIC_PC_W-1:0]         program_counter_q,
  output logic                          irq_request_q,
  input  wire logic                     timer_overflow,
  input  wire logic                     ext_pin_event,
  input  wire logic [3:0]               change_watch_pins,
  input  wire logic                     eeprom_done_flag,
  output logic [7:0]                    rf_addr_q,
  output logic                          rf_rd_q,
  output logic                          rf_wr_q,
  output logic [7:0]                    rf_wdata_q,
  input  wire logic [7:0]               rf_rdata
);
  import cfic_pkg::*;

  // ****************************************
  // state
  // ****************************************
  logic                     aw_have_q, w_have_q, wstrb0_q;
  logic [`CFIC_ADDR_W-1:0]  awaddr_q;
  logic [7:0]               wbyte_q;
  cfic_rd_state_t           rd_state_q, rd_state_d;
  logic                     gie_q, tmr_flag_q, ext_flag_q, chg_flag_q;
  logic [3:0]               en_q;
  logic [3:0]               watch_prev_q;
  logic [`CFIC_PCH_W-1:0]   pch_q;
  logic [7:0]               ptr_q;
  logic [`CFIC_PC_W-1:0]    pc_d, stk_top;

  // ****************************************
  // register decode
  // ****************************************
  function automatic logic is_own(input logic [7:0] idx);
    is_own = (idx == `CFIC_IDX_PCL) || (idx == `CFIC_IDX_PTR) ||
             (idx == `CFIC_IDX_PCH) || (idx == `CFIC_IDX_INTERRUPT_CONTROL);
  endfunction : is_own

  wire [7:0] interrupt_control_rd = {gie_q, en_q, tmr_flag_q, ext_flag_q, chg_flag_q};

  // write side: the handshake holds address and data until both are here
  wire       aw_take  = awvalid & awready_q;
  wire       w_take   = wvalid & wready_q;
  wire       wr_fire  = aw_have_q & w_have_q;
  wire [7:0] wr_idx   = awaddr_q[9:2];
  wire       wr_hi_ok = awaddr_q[`CFIC_ADDR_W-1:10] == `CFIC_HI_ZERO;
  wire       wr_win   = wr_hi_ok & (wr_idx == `CFIC_IDX_WINDOW);
  // pointer alone forms the address, no bank bit
  wire [7:0] wr_tgt   = wr_win ? ptr_q : wr_idx;
  wire       wr_map   = wr_win | (wr_hi_ok & is_own(wr_idx));
  wire       wr_en    = wr_fire & wstrb0_q & wr_map;
  // pointer zero matches no target, so the write falls away
  wire       wr_ext   = wr_en & wr_win & (ptr_q != `CFIC_IDX_WINDOW) & !is_own(ptr_q);
  wire       wr_pcl   = wr_en & (wr_tgt == `CFIC_IDX_PCL);
  wire       wr_ptr   = wr_en & (wr_tgt == `CFIC_IDX_PTR);
  wire       wr_pch   = wr_en & (wr_tgt == `CFIC_IDX_PCH);
  wire       wr_ic    = wr_en & (wr_tgt == `CFIC_IDX_INTERRUPT_CONTROL);
  wire       aw_have_d = wr_fire ? 1'b0 : (aw_have_q | aw_take);
  wire       w_have_d  = wr_fire ? 1'b0 : (w_have_q | w_take);
  wire       bvalid_d  = wr_fire | (bvalid_q & !bready);

  // read side
  wire       ar_take  = arvalid & arready_q;
  wire [7:0] rd_idx   = araddr[9:2];
  wire       rd_hi_ok = araddr[`CFIC_ADDR_W-1:10] == `CFIC_HI_ZERO;
  wire       rd_win   = rd_hi_ok & (rd_idx == `CFIC_IDX_WINDOW);
  wire [7:0] rd_tgt   = rd_win ? ptr_q : rd_idx;
  wire       rd_map   = rd_win | (rd_hi_ok & is_own(rd_idx));
  wire       rd_ext   = rd_win & (ptr_q != `CFIC_IDX_WINDOW) & !is_own(ptr_q);
  // pointer zero falls to the last arm, which is zero
  // plain mux, so readback tracks the registers even with the address unchanged
  wire [7:0] rd_local = !rd_map                      ? `CFIC_BYTE_ZERO :
                        (rd_tgt == `CFIC_IDX_PCL)    ? program_counter_q[7:0] :
                        (rd_tgt == `CFIC_IDX_PTR)    ? ptr_q :
                        (rd_tgt == `CFIC_IDX_PCH)    ? {`CFIC_PAD_ZERO, pch_q} :
                        (rd_tgt == `CFIC_IDX_INTERRUPT_CONTROL) ? interrupt_control_rd : `CFIC_BYTE_ZERO;

  // ****************************************
  // bus write channel
  // ****************************************
  // one write in flight; ready drops while a response is pending
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `CFIC_RESP_OKAY;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      awready_q <= !aw_have_d & !bvalid_d;
      wready_q  <= !w_have_d & !bvalid_d;
      bvalid_q  <= bvalid_d;
      if (wr_fire) begin
        bresp_q <= wr_map ? `CFIC_RESP_OKAY : `CFIC_RESP_SLVERR;
      end
    end
  end

  // payload capture, no reset needed
  always_ff @(posedge aclk) begin
    if (aw_take) begin
      awaddr_q <= awaddr;
    end
    if (w_take) begin
      wbyte_q  <= wdata[7:0];
      wstrb0_q <= wstrb[0];
    end
  end

  // ****************************************
  // bus read channel
  // ****************************************
  // external reads spend one cycle waiting on the register file
  always_comb begin
    rd_state_d = rd_state_q;
    case (rd_state_q)
      CFIC_RD_IDLE: if (ar_take) rd_state_d = rd_ext ? CFIC_RD_EXT : CFIC_RD_RESP;
      CFIC_RD_EXT:  rd_state_d = CFIC_RD_RESP;
      CFIC_RD_RESP: if (rready) rd_state_d = CFIC_RD_IDLE;
      default:      rd_state_d = CFIC_RD_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_q <= CFIC_RD_IDLE;
      arready_q  <= 1'b0;
      rvalid_q   <= 1'b0;
      rdata_q    <= '0;
      rresp_q    <= `CFIC_RESP_OKAY;
    end else begin
      rd_state_q <= rd_state_d;
      arready_q  <= rd_state_d == CFIC_RD_IDLE;
      rvalid_q   <= rd_state_d == CFIC_RD_RESP;
      if (ar_take) begin
        rdata_q <= {`CFIC_RDATA_PAD, rd_local};
        rresp_q <= rd_map ? `CFIC_RESP_OKAY : `CFIC_RESP_SLVERR;
      end else if (rd_state_q == CFIC_RD_EXT) begin
        rdata_q <= {`CFIC_RDATA_PAD, rf_rdata};
      end
    end
  end

  // ****************************************
  // register file side port
  // ****************************************
  // strobes carry the pointer as address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rf_rd_q    <= 1'b0;
      rf_wr_q    <= 1'b0;
      rf_addr_q  <= `CFIC_BYTE_ZERO;
      rf_wdata_q <= `CFIC_BYTE_ZERO;
    end else begin
      rf_rd_q    <= ar_take & rd_ext;
      rf_wr_q    <= wr_ext;
      rf_addr_q  <= ptr_q;
      rf_wdata_q <= wbyte_q;
    end
  end

  // ****************************************
  // interrupt control
  // ****************************************
  // any watched pin differing from last cycle's sample
  wire chg_event = |(change_watch_pins ^ watch_prev_q);

  always_ff @(posedge aclk) begin
    watch_prev_q <= change_watch_pins;
  end

  // flag left out of reset on purpose
  // set wins over a software clear in the same cycle
  always_ff @(posedge aclk) begin
    chg_flag_q <= chg_event | (wr_ic ? wbyte_q[`CFIC_B_CHG_FLAG] : chg_flag_q);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gie_q      <= 1'b0;
      en_q       <= `CFIC_EN_RESET;
      tmr_flag_q <= 1'b0;
      ext_flag_q <= 1'b0;
    end else begin
      if (wr_ic) begin
        gie_q <= wbyte_q[`CFIC_B_GIE];
        en_q  <= wbyte_q[`CFIC_B_EN_HI:`CFIC_B_EN_LO];
      end
      // hardware only sets, event beats clear
      // no enable term in the set path
      tmr_flag_q <= timer_overflow | (wr_ic ? wbyte_q[`CFIC_B_TMR_FLAG] : tmr_flag_q);
      ext_flag_q <= ext_pin_event | (wr_ic ? wbyte_q[`CFIC_B_EXT_FLAG] : ext_flag_q);
    end
  end

  // enables in order eeprom, timer, pin, change
  wire [3:0] src_live = en_q & {eeprom_done_flag, tmr_flag_q, ext_flag_q, chg_flag_q};

  // global gate over the masked sources
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_request_q <= 1'b0;
    end else begin
      irq_request_q <= gie_q & (|src_live);
    end
  end

  // ****************************************
  // program counter and stack
  // ****************************************
  wire is_push = (seq_op == CFIC_OP_CALL) | (seq_op == CFIC_OP_IRQ_ACK);
  wire is_pop  = (seq_op == CFIC_OP_RET) | (seq_op == CFIC_OP_RET_LIT) |
                 (seq_op == CFIC_OP_RET_HANDLER);

  // pointer stays inside, no bus path to it
  // no overflow or underflow output exists
  cfic_stack u_stack (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .push      (is_push),
    .pop       (is_pop),
    .push_data (program_counter_q),
    .top_q     (stk_top)
  );

  // sequencer commands other than step outrank a bus write to the low byte; step yields to it
  always_comb begin
    case (seq_op)
      // 11-bit target, page bits forced to page zero
      CFIC_OP_CALL, CFIC_OP_JUMP: pc_d = {`CFIC_PAGE_ZERO, seq_target};
      CFIC_OP_RET, CFIC_OP_RET_LIT, CFIC_OP_RET_HANDLER: pc_d = stk_top;
      CFIC_OP_IRQ_ACK: pc_d = `CFIC_IRQ_VECTOR;
      // low byte write pulls upper bits from holding register
      CFIC_OP_STEP: pc_d = wr_pcl ? {pch_q, wbyte_q} : program_counter_q + `CFIC_PC_ONE;
      default: pc_d = wr_pcl ? {pch_q, wbyte_q} : program_counter_q;
    endcase
  end

  // full 13-bit counter, only low byte readable
  // holding register moves only on its own write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      program_counter_q <= `CFIC_PC_RESET;
      pch_q             <= `CFIC_PCH_RESET;
      ptr_q             <= `CFIC_BYTE_ZERO;
    end else begin
      program_counter_q <= pc_d;
      if (wr_pch) pch_q <= wbyte_q[`CFIC_PCH_W-1:0];
      if (wr_ptr) ptr_q <= wbyte_q;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_gie_blocks_all: assert property (
    !gie_q |=> !irq_request_q) else $error("request raised with global enable clear");
  a_request_has_src: assert property (
    $rose(irq_request_q) |-> $past(gie_q) && ($past(src_live) != 4'h0))
    else $error("request without enabled flag");
  a_src_enable_gate: assert property (
    gie_q && (src_live == 4'h0) |=> !irq_request_q) else $error("masked source requested");
  a_tmr_sets: assert property (
    timer_overflow |=> tmr_flag_q) else $error("timer flag not set");
  a_tmr_sticky: assert property (
    tmr_flag_q && !wr_ic |=> tmr_flag_q [*1]) else $error("timer flag dropped by hardware");
  a_ext_sets: assert property (
    ext_pin_event && !gie_q && !en_q[1] |=> ext_flag_q) else $error("pin flag not set");
  a_chg_sets: assert property (
    chg_event |=> chg_flag_q) else $error("change flag not set");
  a_pcl_load: assert property (
    wr_pcl && (seq_op == CFIC_OP_NONE) |=> program_counter_q == {$past(pch_q), $past(wbyte_q)})
    else $error("low byte write loaded wrong counter");
  a_page_ignored: assert property (
    seq_op == CFIC_OP_JUMP |=> program_counter_q[12:11] == `CFIC_PAGE_ZERO)
    else $error("page bits reached the counter");
  a_call_return: assert property (
    (seq_op == CFIC_OP_CALL) ##1 (seq_op == CFIC_OP_RET) |=>
    program_counter_q == $past(program_counter_q, 2)) else $error("return lost address");
  a_pch_kept: assert property (
    (is_push || is_pop) && !wr_pch |=> $stable(pch_q)) else $error("holding changed by stack");
  a_win_zero_nop: assert property (
    wr_en && wr_win && (ptr_q == `CFIC_IDX_WINDOW) |=>
    $stable({gie_q, en_q, pch_q, ptr_q}) && !rf_wr_q)
    else $error("window write through pointer zero had effect");
  a_win_zero_read: assert property (
    ar_take && rd_win && (ptr_q == `CFIC_IDX_WINDOW) |=> rdata_q[7:0] == `CFIC_BYTE_ZERO)
    else $error("window read through pointer zero not zero");

  c_irq_raised:  cover property (gie_q ##1 $rose(irq_request_q));
  c_ext_read:    cover property (rf_rd_q ##1 rvalid_q);
  c_call_return: cover property ((seq_op == CFIC_OP_CALL) ##1 (seq_op == CFIC_OP_RET));
endmodule : cfic_top
